/* common/mds_map.svh */
// Offsets, field positions and constants of the arithmetic unit
`ifndef MDS_MAP_SVH
`define MDS_MAP_SVH
`define MDS_OFS_CTRL 32'h0000_0000
`define MDS_OFS_SRC_A 32'h0000_0004
`define MDS_OFS_SRC_B 32'h0000_0008
`define MDS_OFS_ACC_LO 32'h0000_000C
`define MDS_OFS_ACC_HI 32'h0000_0010
`define MDS_OFS_RES_LO 32'h0000_0014
`define MDS_OFS_RES_HI 32'h0000_0018
`define MDS_OFS_STATUS 32'h0000_001C
`define MDS_OFS_DEST 32'h0000_0020
`define MDS_AMSB 5
`define MDS_ALSB 2
`define MDS_CTRL_OP_LSB 0
`define MDS_CTRL_OP_MSB 3
`define MDS_CTRL_S_BIT 4
`define MDS_CTRL_SHT_BIT 5
`define MDS_CTRL_SH_LSB 8
`define MDS_CTRL_SH_MSB 12
`define MDS_CTRL_N_LSB 16
`define MDS_CTRL_N_MSB 21
`define MDS_CTRL_GO_BIT 31
`define MDS_ST_Q_BIT 27
`define MDS_ST_V_BIT 28
`define MDS_ST_C_BIT 29
`define MDS_ST_Z_BIT 30
`define MDS_ST_N_BIT 31
`define MDS_DST_D_LSB 0
`define MDS_DST_D_MSB 3
`define MDS_DST_H_LSB 4
`define MDS_DST_H_MSB 7
`define MDS_DST_OMIT_BIT 8
`define MDS_DST_N_LSB 12
`define MDS_DST_N_MSB 15
`define MDS_DIV_STEPS 6'd32
`define MDS_ZERO32 32'h0000_0000
`define MDS_ONES32 32'hFFFF_FFFF
`endif

/* common/mds_pkg.sv */
// Types shared by the arithmetic unit
package mds_pkg;
    typedef enum logic [3:0] {
        MDS_MULT_LOW = 4'h0,
        MDS_MULT_ACCUM = 4'h1,
        MDS_MULT_SUBTRACT = 4'h2,
        MDS_UNSIGNED_LONG_MULT = 4'h3,
        MDS_UNSIGNED_LONG_MULT_ACCUM = 4'h4,
        MDS_SIGNED_LONG_MULT = 4'h5,
        MDS_SIGNED_LONG_MULT_ACCUM = 4'h6,
        MDS_SIGNED_DIVIDE = 4'h7,
        MDS_UNSIGNED_DIVIDE = 4'h8,
        MDS_SIGNED_SATURATE = 4'h9,
        MDS_UNSIGNED_SATURATE = 4'hA
    } mds_op_e;

    typedef enum logic [2:0] {
        MDS_ST_IDLE = 3'b001,
        MDS_ST_DIV = 3'b010,
        MDS_ST_DONE = 3'b100
    } mds_state_e;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } mds_ahb_req_s;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
        logic q;
    } mds_flags_s;
endpackage

/* logic/mds_unit.sv */
// Multiply, divide and saturate unit behind an AHB-Lite register slave
`timescale 1ns/1ps
`include "mds_map.svh"

module mds_unit (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire mds_pkg::mds_ahb_req_s ahb_req,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic busy,
    output logic done
);
    import mds_pkg::*;

    logic [31:0] ctrl_q;
    logic [31:0] src_a_q;
    logic [31:0] src_b_q;
    logic [31:0] acc_lo_q;
    logic [31:0] acc_hi_q;
    logic [31:0] res_lo_q;
    logic [31:0] res_hi_q;
    logic [15:0] dest_q;
    mds_flags_s flags_q;
    mds_state_e state_q;
    logic [5:0] div_cnt_q;
    logic [31:0] div_quo_q;
    logic [32:0] div_rem_q;
    logic [31:0] div_dvs_q;
    logic div_neg_q;
    logic [31:0] hrdata_q;
    logic busy_q;
    logic done_q;
    logic dp_wr_q;
    logic dp_rd_q;
    logic [`MDS_AMSB:`MDS_ALSB] dp_addr_q;

    // AHB address phase capture
    logic addr_valid;
    assign addr_valid = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dp_wr_q <= 1'b0;
            dp_rd_q <= 1'b0;
            dp_addr_q <= '0;
        end else begin
            dp_wr_q <= addr_valid && ahb_req.hwrite;
            dp_rd_q <= addr_valid && !ahb_req.hwrite;
            if (addr_valid) begin
                dp_addr_q <= ahb_req.haddr[`MDS_AMSB:`MDS_ALSB];
            end
        end
    end

    function automatic logic hit(input logic [`MDS_AMSB:`MDS_ALSB] a, input logic [31:0] ofs);
        hit = (a == ofs[`MDS_AMSB:`MDS_ALSB]);
    endfunction

    mds_op_e op;
    assign op = mds_op_e'(ctrl_q[`MDS_CTRL_OP_MSB:`MDS_CTRL_OP_LSB]);
    logic start;
    assign start = dp_wr_q && hit(dp_addr_q, `MDS_OFS_CTRL) && hwdata[`MDS_CTRL_GO_BIT]
        && (state_q == MDS_ST_IDLE);
    mds_op_e new_op;
    assign new_op = mds_op_e'(hwdata[`MDS_CTRL_OP_MSB:`MDS_CTRL_OP_LSB]);

    // Multiply datapath
    logic [63:0] prod_u;
    logic signed [63:0] prod_s;
    logic [63:0] acc64;
    logic [31:0] mul_lo;
    logic [63:0] long_res;
    assign prod_u = {32'h0000_0000, src_a_q} * {32'h0000_0000, src_b_q};
    assign prod_s = $signed({{32{src_a_q[31]}}, src_a_q}) * $signed({{32{src_b_q[31]}}, src_b_q});
    assign acc64 = {acc_hi_q, acc_lo_q};

    always_comb begin
        mul_lo = prod_u[31:0];
        long_res = prod_u;
        unique case (op)
            MDS_MULT_ACCUM: mul_lo = prod_u[31:0] + acc_lo_q;
            MDS_MULT_SUBTRACT: mul_lo = acc_lo_q - prod_u[31:0];
            MDS_UNSIGNED_LONG_MULT_ACCUM: long_res = prod_u + acc64;
            MDS_SIGNED_LONG_MULT: long_res = prod_s;
            MDS_SIGNED_LONG_MULT_ACCUM: long_res = prod_s + acc64;
            default: ;
        endcase
    end

    // Saturation datapath
    logic [4:0] sh_amt;
    logic [5:0] sat_n;
    logic signed [63:0] shifted;
    logic signed [63:0] sat_hi;
    logic signed [63:0] sat_lo;
    logic [31:0] sat_res;
    logic sat_hit;
    assign sh_amt = ctrl_q[`MDS_CTRL_SH_MSB:`MDS_CTRL_SH_LSB];
    assign sat_n = ctrl_q[`MDS_CTRL_N_MSB:`MDS_CTRL_N_LSB];

    always_comb begin
        if (ctrl_q[`MDS_CTRL_SHT_BIT]) begin
            shifted = $signed({{32{src_b_q[31]}}, src_b_q}) >>> sh_amt;
        end else begin
            shifted = $signed({32'h0000_0000, src_b_q << sh_amt});
            shifted = $signed({{32{shifted[31]}}, shifted[31:0]});
        end
        if (op == MDS_SIGNED_SATURATE) begin
            sat_hi = (64'sd1 <<< (sat_n - 6'd1)) - 64'sd1;
            sat_lo = -(64'sd1 <<< (sat_n - 6'd1));
        end else begin
            sat_hi = (64'sd1 <<< sat_n) - 64'sd1;
            sat_lo = 64'sd0;
        end
        sat_hit = 1'b1;
        if (shifted > sat_hi) begin
            sat_res = sat_hi[31:0];
        end else if (shifted < sat_lo) begin
            sat_res = sat_lo[31:0];
        end else begin
            sat_res = shifted[31:0];
            sat_hit = 1'b0;
        end
    end

    // Divider operand preparation, magnitude based for truncation toward zero
    // Operands load on the go write, so signedness follows the op being written
    logic signed_divide;
    logic [31:0] mag_a;
    logic [31:0] mag_b;
    assign signed_divide = (new_op == MDS_SIGNED_DIVIDE);
    assign mag_a = (signed_divide && src_a_q[31]) ? (`MDS_ZERO32 - src_a_q) : src_a_q;
    assign mag_b = (signed_divide && src_b_q[31]) ? (`MDS_ZERO32 - src_b_q) : src_b_q;
    logic [32:0] trial;
    assign trial = {div_rem_q[31:0], div_quo_q[31]} - {1'b0, div_dvs_q};

    // Control state machine
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= MDS_ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            unique case (state_q)
                MDS_ST_IDLE: begin
                    if (start && (new_op == MDS_SIGNED_DIVIDE || new_op == MDS_UNSIGNED_DIVIDE)
                        && src_b_q != `MDS_ZERO32) begin
                        state_q <= MDS_ST_DIV;
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                    end else if (start) begin
                        state_q <= MDS_ST_DONE;
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                    end
                end
                MDS_ST_DIV: begin
                    if (div_cnt_q == `MDS_DIV_STEPS) begin
                        state_q <= MDS_ST_DONE;
                    end
                end
                MDS_ST_DONE: begin
                    state_q <= MDS_ST_IDLE;
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                default: state_q <= MDS_ST_IDLE;
            endcase
        end
    end

    // Restoring divider, one quotient bit per cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_q <= '0;
            div_quo_q <= '0;
            div_rem_q <= '0;
            div_dvs_q <= '0;
            div_neg_q <= 1'b0;
        end else if (state_q == MDS_ST_IDLE) begin
            div_cnt_q <= '0;
            div_quo_q <= mag_a;
            div_rem_q <= '0;
            div_dvs_q <= mag_b;
            div_neg_q <= signed_divide && (src_a_q[31] ^ src_b_q[31]);
        end else if (state_q == MDS_ST_DIV && div_cnt_q != `MDS_DIV_STEPS) begin
            div_cnt_q <= div_cnt_q + 6'd1;
            if (!trial[32]) begin
                div_rem_q <= trial;
                div_quo_q <= {div_quo_q[30:0], 1'b1};
            end else begin
                div_rem_q <= {div_rem_q[31:0], div_quo_q[31]};
                div_quo_q <= {div_quo_q[30:0], 1'b0};
            end
        end
    end

    // Result and flag update at completion
    logic flag_wr;
    assign flag_wr = dp_wr_q && hit(dp_addr_q, `MDS_OFS_STATUS);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            res_lo_q <= '0;
            res_hi_q <= '0;
        end else if (state_q == MDS_ST_DONE) begin
            unique case (op)
                MDS_MULT_LOW, MDS_MULT_ACCUM, MDS_MULT_SUBTRACT: res_lo_q <= mul_lo;
                MDS_UNSIGNED_LONG_MULT, MDS_UNSIGNED_LONG_MULT_ACCUM, MDS_SIGNED_LONG_MULT,
                MDS_SIGNED_LONG_MULT_ACCUM: begin
                    res_lo_q <= long_res[31:0];
                    res_hi_q <= long_res[63:32];
                end
                MDS_SIGNED_SATURATE, MDS_UNSIGNED_SATURATE: res_lo_q <= sat_res;
                MDS_SIGNED_DIVIDE, MDS_UNSIGNED_DIVIDE: begin
                    if (div_dvs_q == `MDS_ZERO32) begin
                        res_lo_q <= `MDS_ZERO32;
                    end else if (div_neg_q) begin
                        res_lo_q <= `MDS_ZERO32 - div_quo_q;
                    end else begin
                        res_lo_q <= div_quo_q;
                    end
                end
                default: res_lo_q <= `MDS_ZERO32;
            endcase
        end
    end

    // Flags: long multiplies and divides touch none
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_q <= '0;
        end else begin
            if (flag_wr) begin
                flags_q.n <= hwdata[`MDS_ST_N_BIT];
                flags_q.z <= hwdata[`MDS_ST_Z_BIT];
                flags_q.c <= hwdata[`MDS_ST_C_BIT];
                flags_q.v <= hwdata[`MDS_ST_V_BIT];
                flags_q.q <= hwdata[`MDS_ST_Q_BIT];
            end
            if (state_q == MDS_ST_DONE && op == MDS_MULT_LOW && ctrl_q[`MDS_CTRL_S_BIT]) begin
                flags_q.n <= mul_lo[31];
                flags_q.z <= (mul_lo == `MDS_ZERO32);
            end
            if (state_q == MDS_ST_DONE && sat_hit
                && (op == MDS_SIGNED_SATURATE || op == MDS_UNSIGNED_SATURATE)) begin
                flags_q.q <= 1'b1;
            end
        end
    end

    // Software-written registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= '0;
            src_a_q <= '0;
            src_b_q <= '0;
            acc_lo_q <= '0;
            acc_hi_q <= '0;
            dest_q <= '0;
        end else if (dp_wr_q && state_q == MDS_ST_IDLE) begin
            if (hit(dp_addr_q, `MDS_OFS_CTRL)) ctrl_q <= hwdata;
            if (hit(dp_addr_q, `MDS_OFS_SRC_A)) src_a_q <= hwdata;
            if (hit(dp_addr_q, `MDS_OFS_SRC_B)) src_b_q <= hwdata;
            if (hit(dp_addr_q, `MDS_OFS_ACC_LO)) acc_lo_q <= hwdata;
            if (hit(dp_addr_q, `MDS_OFS_ACC_HI)) acc_hi_q <= hwdata;
            if (hit(dp_addr_q, `MDS_OFS_DEST)) dest_q <= hwdata[15:0];
        end
    end

    // Destination index reported back; omitted field falls back to first source
    logic [3:0] eff_dest;
    assign eff_dest = dest_q[`MDS_DST_OMIT_BIT] ? dest_q[`MDS_DST_N_MSB:`MDS_DST_N_LSB]
        : dest_q[`MDS_DST_D_MSB:`MDS_DST_D_LSB];

    // Read mux, decoded from the live address-phase address and registered so data stands in the data phase
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = `MDS_ZERO32;
        unique case (ahb_req.haddr[`MDS_AMSB:`MDS_ALSB])
            4'(`MDS_OFS_CTRL >> `MDS_ALSB): rd_mux = ctrl_q;
            4'(`MDS_OFS_SRC_A >> `MDS_ALSB): rd_mux = src_a_q;
            4'(`MDS_OFS_SRC_B >> `MDS_ALSB): rd_mux = src_b_q;
            4'(`MDS_OFS_ACC_LO >> `MDS_ALSB): rd_mux = acc_lo_q;
            4'(`MDS_OFS_ACC_HI >> `MDS_ALSB): rd_mux = acc_hi_q;
            4'(`MDS_OFS_RES_LO >> `MDS_ALSB): rd_mux = res_lo_q;
            4'(`MDS_OFS_RES_HI >> `MDS_ALSB): rd_mux = res_hi_q;
            4'(`MDS_OFS_STATUS >> `MDS_ALSB): rd_mux = {flags_q, 27'h000_0000};
            4'(`MDS_OFS_DEST >> `MDS_ALSB): rd_mux = {16'h0000, dest_q[15:8], dest_q[7:4],
                eff_dest};
            default: rd_mux = `MDS_ZERO32;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_q <= '0;
        end else if (addr_valid && !ahb_req.hwrite) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign busy = busy_q;
    assign done = done_q;
endmodule // mds_unit

/* bench/mds_unit_assertions.sv */
// Port-level checks of the arithmetic unit's bus answers and sequencing
`timescale 1ns/1ps
`include "mds_map.svh"
module mds_unit_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire mds_pkg::mds_ahb_req_s ahb_req,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic busy,
    input wire logic done
);
    import mds_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    sequence ctrl_addr_s;
        ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite
            && ahb_req.haddr == `MDS_OFS_CTRL;
    endsequence
    sequence go_s(logic div);
        ctrl_addr_s ##1 (hwdata[31] && !busy && ((hwdata[3:0] inside {4'h7, 4'h8}) == div));
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer is not zero-wait OKAY");
    quick_op_a: assert property (go_s(1'b0) |=> busy ##1 (!busy && done))
        else $error("short operation timing wrong");
    div_op_a: assert property (go_s(1'b1) |=> busy ##[1:34] (!busy && done))
        else $error("divide did not finish in time");
    busy_cause_a: assert property ($rose(busy) |->
        $past(hwdata[31]) && $past(ahb_req.hwrite, 2)) else $error("busy without go write");
    busy_excl_a: assert property (busy |-> !done)
        else $error("busy and done together");
    done_hold_a: assert property (done ##1 !busy |-> done)
        else $error("done dropped without a start");
    fall_done_a: assert property ($fell(busy) |-> done)
        else $error("operation ended without done");
    rd_hold_a: assert property (!(ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]
        && !ahb_req.hwrite) |=> $stable(hrdata)) else $error("read data changed without read");
endmodule // mds_unit_checker

/* bench/mds_host.sv */
// Bus master model standing for the decoder and register file
`timescale 1ns/1ps
module mds_host (
    input wire logic mclk,
    output mds_pkg::mds_ahb_req_s bus_req,
    output logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout
);
    import mds_pkg::*;
    int timeouts = 0;
    initial begin
        bus_req = '0;
        hwdata = 32'h0000_0000;
    end
    // One single word transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
            output logic [31:0] rd);
        int n;
        n = 0;
        bus_req.haddr <= addr;
        bus_req.htrans <= 2'b10;
        bus_req.hwrite <= wr;
        bus_req.hsize <= 3'b010;
        bus_req.hsel <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        bus_req.htrans <= 2'b00;
        bus_req.hsel <= 1'b0;
        bus_req.haddr <= ~addr;
        hwdata <= wr ? wd : ~hwdata;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 32);
        rd = hrdata;
        // Released data line must not keep its last value
        hwdata <= ~wd;
        if (n >= 32) begin
            timeouts++;
        end
    endtask
endmodule // mds_host

/* bench/mds_unit_tb.sv */
// Self-checking bench of the arithmetic unit
`timescale 1ns/1ps
`include "mds_map.svh"
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("mismatch at %0t: got %h expected %h", $time, g, e); \
    end \
end
module mds_unit_tb;
    import mds_pkg::*;
    logic mclk;
    logic sys_rst;
    mds_ahb_req_s host_req;
    mds_ahb_req_s bus_req;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic busy;
    logic done;
    logic [31:0] st;
    logic [31:0] r;
    int fails = 0;
    int total_checks = 0;
    int seed = 28561;
    always #50 mclk = ~mclk;
    always_comb begin
        bus_req = host_req;
        bus_req.hready = hreadyout;
    end
    mds_host i_host (.mclk(mclk), .bus_req(host_req), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout));
    mds_unit i_dut (.mclk(mclk), .sys_rst(sys_rst), .ahb_req(bus_req), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy), .done(done));
    task automatic conclude();
        fails += i_host.timeouts;
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        i_host.xfer(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        i_host.xfer(1'b0, a, 32'h0000_0000, d);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (!(busy === 1'b0 && done === 1'b1) && n < 60);
        if (n >= 60) begin
            fails++;
            conclude();
        end else begin
            @(posedge mclk);
        end
    endtask
    // Upper half carries the shifted input for saturations
    function automatic logic [63:0] expect_res(input logic [3:0] op, input logic [31:0] a, b,
            lo, hi, input logic sht, input logic [4:0] sh, input logic [5:0] n);
        logic [31:0] v;
        logic [31:0] q;
        longint sv;
        longint mx;
        longint pr;
        if (sht) v = $signed(b) >>> sh;
        else v = b << sh;
        sv = longint'($signed(v));
        pr = longint'($signed(a)) * longint'($signed(b));
        q = $signed(a) / $signed(b);
        case (op)
            4'h0: return {32'h0000_0000, a * b};
            4'h1: return {32'h0000_0000, lo + a * b};
            4'h2: return {32'h0000_0000, lo - a * b};
            4'h3: return 64'(a) * 64'(b);
            4'h4: return {hi, lo} + 64'(a) * 64'(b);
            4'h5: return 64'(pr);
            4'h6: return {hi, lo} + 64'(pr);
            4'h7: return {32'h0000_0000, (b == 0) ? 32'h0000_0000 : q};
            4'h8: return {32'h0000_0000, (b == 0) ? 32'h0000_0000 : a / b};
            4'h9: begin
                mx = (longint'(1) <<< (n - 1)) - 1;
                pr = (sv > mx) ? mx : ((sv < -mx - 1) ? -mx - 1 : sv);
                return {v, 32'(pr)};
            end
            4'hA: begin
                mx = (longint'(1) << n) - 1;
                pr = (sv > mx) ? mx : ((sv < 0) ? 0 : sv);
                return {v, 32'(pr)};
            end
            default: return {32'h0000_0000, 32'h0000_0000};
        endcase
    endfunction
    task automatic run_op(input logic [3:0] op, input logic [31:0] a, b, lo, hi,
            input logic s, sht, input logic [4:0] sh, input logic [5:0] n, input logic [15:0] dst);
        logic [63:0] e;
        e = expect_res(op, a, b, lo, hi, sht, sh, n);
        wr(`MDS_OFS_SRC_A, a);
        wr(`MDS_OFS_SRC_B, b);
        wr(`MDS_OFS_ACC_LO, lo);
        wr(`MDS_OFS_ACC_HI, hi);
        wr(`MDS_OFS_DEST, {16'h0000, dst});
        wr(`MDS_OFS_CTRL, {1'b1, 9'h000, n, 3'h0, sh, 2'h0, sht, s, op});
        wait_done();
        rd(`MDS_OFS_RES_LO, r);
        `CHK(r, e[31:0])
        if (op inside {[4'h3:4'h6]}) begin
            rd(`MDS_OFS_RES_HI, r);
            `CHK(r, e[63:32])
        end
        if (s && op == 4'h0) begin
            st[31] = e[31];
            st[30] = (e[31:0] == 32'h0000_0000);
        end
        if (op >= 4'h9 && e[63:32] != e[31:0]) st[27] = 1'b1;
        rd(`MDS_OFS_STATUS, r);
        `CHK(r[31:27], st[31:27])
        if (op inside {4'h0, 4'h7, 4'h8}) begin
            rd(`MDS_OFS_DEST, r);
            `CHK(r[3:0], dst[8] ? dst[15:12] : dst[3:0])
        end
    endtask
    task automatic check_zero();
        for (int a = 0; a <= 36; a += 4) begin
            rd(32'(a), r);
            `CHK(r, 32'h0000_0000)
        end
    endtask
    initial begin
        logic [3:0] op;
        logic [4:0] sh;
        logic [5:0] n;
        logic [15:0] dst;
        logic [31:0] dd;
        logic sht;
        logic s;
        mclk = 1'b0;
        sys_rst = 1'b1;
        st = 32'h0000_0000;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        check_zero();
        run_op(4'h7, 32'hFFFF_FFF9, 32'h0000_0002, 0, 0, 0, 0, 0, 0, 16'h3105);
        run_op(4'h8, 32'h0000_0064, 0, 0, 0, 0, 0, 0, 0, 16'h0012);
        run_op(4'h0, 32'hFFFF_FFFF, 32'h0000_0001, 0, 0, 1, 0, 0, 0, 16'h2154);
        run_op(4'h0, 32'h0001_0000, 32'h0001_0000, 0, 0, 1, 0, 0, 0, 16'h0003);
        run_op(4'h9, 0, 32'h0000_1234, 0, 0, 0, 0, 5'd4, 6'd16, 16'h0001);
        wr(`MDS_OFS_STATUS, 32'h0000_0000);
        st = 32'h0000_0000;
        run_op(4'hA, 0, 32'h8000_0000, 0, 0, 0, 1, 5'd31, 6'd7, 16'h0001);
        wr(`MDS_OFS_STATUS, 32'hF800_0000);
        st = 32'hF800_0000;
        run_op(4'h6, 32'h8000_0000, 32'h7FFF_FFFF, 1, 2, 0, 0, 0, 0, 16'h0010);
        for (int i = 0; i < 80; i++) begin
            op = 4'($unsigned($random(seed)) % 11);
            sht = 1'($random(seed));
            sh = 5'($random(seed));
            if (sht && sh == 5'd0) sh = 5'd1;
            n = (op == 4'h9) ? 6'(1 + $unsigned($random(seed)) % 32)
                : 6'($unsigned($random(seed)) % 32);
            dd = $random(seed);
            s = (op == 4'h0) && dd[7];
            dst = {1'b0, dd[2:0], 3'b000, dd[6], 1'b0, dd[5:3] ^ 3'b001, 1'b0, dd[5:3]};
            run_op(op, $random(seed), $random(seed), $random(seed), $random(seed), s, sht, sh, n,
                dst);
        end
        // Operand write and second go during a divide are both ignored
        wr(`MDS_OFS_SRC_A, 32'h0000_0064);
        wr(`MDS_OFS_SRC_B, 32'h0000_0007);
        wr(`MDS_OFS_CTRL, 32'h8000_0008);
        wr(`MDS_OFS_SRC_A, 32'h0000_0000);
        wr(`MDS_OFS_CTRL, 32'h8000_0000);
        wait_done();
        rd(`MDS_OFS_RES_LO, r);
        `CHK(r, 32'h0000_000E)
        wr(`MDS_OFS_CTRL, 32'h8000_0007);
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        check_zero();
        conclude();
    end
endmodule // mds_unit_tb
bind mds_unit mds_unit_checker i_chk (.mclk(mclk), .sys_rst(sys_rst), .ahb_req(ahb_req),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy),
    .done(done));
